// ### verilog/switch_defs.svh
// timing constants and field positions shared by both ends
`ifndef SWITCH_DEFS_SVH
`define SWITCH_DEFS_SVH
`define CLK_MHZ            200
`define T_WRST_US          10
`define T_ENBL_NS          5000
`define T_CSB_NS           1000
`define T_LEAD_NS          500
`define F_SPI_MAX_KHZ      8000
`define T_IN_MS            250
`define T_WDTO_MS          310
`define CYC_WRST           (`T_WRST_US * `CLK_MHZ)
`define CYC_ENBL           ((`T_ENBL_NS * `CLK_MHZ + 999) / 1000)
`define CYC_CSB            ((`T_CSB_NS * `CLK_MHZ + 999) / 1000)
`define CYC_LEAD           ((`T_LEAD_NS * `CLK_MHZ + 999) / 1000)
`define CYC_SCK_HALF       ((`CLK_MHZ * 1000 + 2 * `F_SPI_MAX_KHZ - 1) / (2 * `F_SPI_MAX_KHZ))
`define CYC_IN             (`T_IN_MS * `CLK_MHZ * 1000)
`define CYC_WDTO           (`T_WDTO_MS * `CLK_MHZ * 1000)
`define FRAME_BITS         16
`define BIT_TOGGLE         15
`define BIT_MODE_LO        0
`define BIT_SENSE_LO       4
`define BIT_SENSE_HI       5
`define BIT_HOLD_EN        6
`define BIT_OC_WIN_LO      8
`define BIT_STALL_EN       10
`define SEL_OFF            2'h0
`endif

// ### verilog/switch_pkg.sv
// types used by the switch end of the link
package switch_pkg;
    typedef enum logic [1:0] {
        MODE_INT_CLK,
        MODE_EXT_CLK,
        MODE_DIRECT,
        MODE_RSVD
    } sw_mode_t;
    typedef enum logic [1:0] {
        SENSE_NONE,
        SENSE_CH0,
        SENSE_CH1,
        SENSE_TEMP
    } sense_src_t;
endpackage

// ### verilog/switch_link_if.sv
// link between the controller and the power switch
`timescale 1ns/1ps
interface switch_link_if;
    logic chip_select_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic wake_reset_n;
    logic direct_input_ch0;
    logic direct_input_ch1;
    logic sync_oe;
    logic pwm_clk;
    modport dev (
        input  chip_select_n, sclk, sdi, wake_reset_n,
        input  direct_input_ch0, direct_input_ch1, pwm_clk,
        output sdo, sync_oe
    );
    modport host (
        output chip_select_n, sclk, sdi, wake_reset_n,
        output direct_input_ch0, direct_input_ch1, pwm_clk,
        input  sdo, sync_oe
    );
endinterface

// ### verilog/switch_ctrl_dev.sv
`timescale 1ns/1ps
`include "switch_defs.svh"
module switch_ctrl_dev #(
    parameter int unsigned          IN_CYCLES   = `CYC_IN,
    parameter int unsigned          WDTO_CYCLES = `CYC_WDTO,
    parameter int unsigned          PWM_DIV     = 1000,
    parameter int unsigned          STAGE_CYC   = 64,
    parameter switch_pkg::sense_src_t MAP1      = switch_pkg::SENSE_CH0,
    parameter switch_pkg::sense_src_t MAP2      = switch_pkg::SENSE_CH1,
    parameter switch_pkg::sense_src_t MAP3      = switch_pkg::SENSE_TEMP
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    switch_link_if.dev      link,
    input  wire logic       vdd_ok,
    input  wire logic [1:0] oc_over,
    input  wire logic       pwm_ext_tick,
    output logic            switch_output_ch0,
    output logic            switch_output_ch1,
    output logic [1:0]      sense_output,
    output logic            sense_oe,
    output logic            hold_active,
    output logic            asleep,
    output logic            fail_safe,
    output logic [15:0]     global_config_reg,
    output logic [1:0]      oc_window
);
    typedef struct packed {
        logic        sleep;
        logic        fsafe;
        logic [31:0] in_cnt;
        logic [31:0] wd_cnt;
        logic        last_tog;
        logic        first_seen;
        logic        in0_d;
        logic        in1_d;
        logic        rst_d;
        logic        cs_d;
        logic        sck_d;
        logic [15:0] shin;
        logic [15:0] shout;
        logic [4:0]  bitn;
        logic [15:0] cfg;
        logic [31:0] pwm_cnt;
        logic        pwm_int;
        logic        pwm_ext;
        logic [1:0]  on;
        logic [1:0]  held_src;
        logic [1:0]  snz;
        logic        soe;
        logic        hold;
        logic        sync_oe;
        logic [1:0]  ocw;
        logic [31:0] oc_cnt;
        logic [1:0]  oc_stage;
    } dev_st_t;
    dev_st_t s_r;
    dev_st_t s_nxt;
    switch_pkg::sw_mode_t m [2];
    logic                 din [2];
    logic                 pwm_src [2];
    logic [1:0]           sel;
    switch_pkg::sense_src_t src;
    logic                 sense_ok;

    assign sel = {s_r.cfg[`BIT_SENSE_HI], s_r.cfg[`BIT_SENSE_LO]};
    assign din[0] = link.direct_input_ch0;
    assign din[1] = link.direct_input_ch1;
    generate
        for (genvar c = 0; c < 2; c++) begin : g_mode
            assign m[c] = switch_pkg::sw_mode_t'(
                s_r.cfg[`BIT_MODE_LO + 2*c +: 2]);
            assign pwm_src[c] = (m[c] == switch_pkg::MODE_EXT_CLK)
                ? s_r.pwm_ext : s_r.pwm_int;
        end
    endgenerate

    always_comb begin
        case (sel)
            2'h1:    src = MAP1;
            2'h2:    src = MAP2;
            2'h3:    src = MAP3;
            default: src = switch_pkg::SENSE_NONE;
        endcase
    end
    // sensing needs logic supply and normal mode; window blocks it
    assign sense_ok = !s_r.fsafe && vdd_ok && !s_r.sleep
        && (s_r.ocw == 2'h0);

    always_comb begin
        s_nxt = s_r;
        s_nxt.in0_d = din[0];
        s_nxt.in1_d = din[1];
        s_nxt.rst_d = link.wake_reset_n;
        s_nxt.cs_d  = link.chip_select_n;
        s_nxt.sck_d = link.sclk;
        // sleep/wake
        if (s_r.sleep && ((din[0] && !s_r.in0_d) || (din[1] && !s_r.in1_d)))
            s_nxt.sleep = 1'b0;
        if (link.wake_reset_n && !s_r.rst_d)
            s_nxt.sleep = 1'b0;
        if (!link.wake_reset_n) begin
            s_nxt.cfg = '0;
            s_nxt.fsafe = 1'b0;
            s_nxt.first_seen = 1'b0;
            s_nxt.wd_cnt = '0;
            if (din[0] || din[1])
                s_nxt.in_cnt = '0;
            else if (s_r.in_cnt >= IN_CYCLES - 1)
                s_nxt.sleep = 1'b1;
            else
                s_nxt.in_cnt = s_r.in_cnt + 32'h1;
        end else begin
            s_nxt.in_cnt = '0;
            // watchdog on the toggle bit of every frame
            if (!s_r.fsafe) begin
                if (s_r.wd_cnt >= WDTO_CYCLES - 1)
                    s_nxt.fsafe = 1'b1;
                else
                    s_nxt.wd_cnt = s_r.wd_cnt + 32'h1;
            end
        end
        // serial port, sampled on mclk; si taken on sclk falling
        if (!link.chip_select_n && s_r.cs_d) begin
            s_nxt.bitn = '0;
            s_nxt.shout = s_r.shin; // daisy-chain: previous frame out
        end
        if (!link.chip_select_n && s_r.sck_d && !link.sclk) begin
            s_nxt.shin = {s_r.shin[14:0], link.sdi};
            s_nxt.bitn = s_r.bitn + 5'h1;
        end
        if (!link.chip_select_n && !s_r.sck_d && link.sclk
            && s_r.bitn != 5'h0)
            s_nxt.shout = {s_r.shout[14:0], 1'b0};
        if (link.chip_select_n && !s_r.cs_d && link.wake_reset_n
            && s_r.bitn == 5'(`FRAME_BITS)) begin
            // partial frames are dropped
            s_nxt.cfg = s_r.shin;
            if (!s_r.first_seen
                || s_r.shin[`BIT_TOGGLE] != s_r.last_tog) begin
                s_nxt.wd_cnt = '0;
                s_nxt.first_seen = 1'b1;
            end
            s_nxt.last_tog = s_r.shin[`BIT_TOGGLE];
        end
        // internal pwm divider; external clock from tick or link pin
        s_nxt.pwm_ext = pwm_ext_tick || link.pwm_clk;
        if (s_r.pwm_cnt >= PWM_DIV - 1) begin
            s_nxt.pwm_cnt = '0;
            s_nxt.pwm_int = !s_r.pwm_int;
        end else
            s_nxt.pwm_cnt = s_r.pwm_cnt + 32'h1;
        for (int c = 0; c < 2; c++) begin
            if (s_r.sleep)
                s_nxt.on[c] = 1'b0;
            else if (m[c] == switch_pkg::MODE_DIRECT || s_r.fsafe)
                s_nxt.on[c] = din[c];
            else
                s_nxt.on[c] = pwm_src[c];
            s_nxt.ocw[c] = oc_over[c] && s_nxt.on[c]
                && (s_r.oc_stage != 2'h3 || s_r.cfg[`BIT_STALL_EN]);
        end
        // staircase stages after turn-on; motor profile keeps window
        if (s_r.on == 2'h0) begin
            s_nxt.oc_cnt = '0;
            s_nxt.oc_stage = '0;
        end else if (s_r.oc_cnt >= STAGE_CYC - 1) begin
            s_nxt.oc_cnt = '0;
            if (s_r.oc_stage != 2'h3)
                s_nxt.oc_stage = s_r.oc_stage + 2'h1;
        end else
            s_nxt.oc_cnt = s_r.oc_cnt + 32'h1;
        // sense output path
        s_nxt.soe = (sel != `SEL_OFF) && sense_ok;
        s_nxt.hold = 1'b0;
        case (src)
            switch_pkg::SENSE_CH0: begin
                s_nxt.hold = !s_r.on[0] && s_r.cfg[`BIT_HOLD_EN];
                if (s_r.on[0])
                    s_nxt.held_src = 2'h1;
            end
            switch_pkg::SENSE_CH1: begin
                s_nxt.hold = !s_r.on[1] && s_r.cfg[`BIT_HOLD_EN];
                if (s_r.on[1])
                    s_nxt.held_src = 2'h2;
            end
            switch_pkg::SENSE_TEMP: s_nxt.held_src = 2'h3;
            default: s_nxt.held_src = 2'h0;
        endcase
        s_nxt.snz = s_nxt.hold ? s_r.held_src : s_nxt.held_src;
        // sync high while sense valid; released on any turn-off
        if ((s_r.on & ~s_nxt.on) != 2'h0)
            s_nxt.sync_oe = 1'b0;
        else
            s_nxt.sync_oe = s_nxt.soe && !s_nxt.hold
                && ((src == switch_pkg::SENSE_CH0 && s_r.on[0])
                 || (src == switch_pkg::SENSE_CH1 && s_r.on[1])
                 || src == switch_pkg::SENSE_TEMP);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.sleep <= 1'b1;
            s_r.cs_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.sdo          = s_r.shout[15];
    assign link.sync_oe      = s_r.sync_oe;
    assign switch_output_ch0 = s_r.on[0];
    assign switch_output_ch1 = s_r.on[1];
    assign sense_output      = s_r.snz;
    assign sense_oe          = s_r.soe;
    assign hold_active       = s_r.hold;
    assign asleep            = s_r.sleep;
    assign fail_safe         = s_r.fsafe;
    assign global_config_reg = s_r.cfg;
    assign oc_window         = s_r.ocw;
endmodule

// ### verilog/switch_ctrl_host.sv
// controller end: frames config words onto the serial link
`timescale 1ns/1ps
`include "switch_defs.svh"
module switch_ctrl_host #(
    parameter int unsigned WRST_CYC = `CYC_WRST,
    parameter int unsigned ENBL_CYC = `CYC_ENBL
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    switch_link_if.host      link,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata
);
    localparam logic [3:0] A_TX   = 4'h0;
    localparam logic [3:0] A_CTRL = 4'h1;
    localparam logic [3:0] A_STAT = 4'h2;
    localparam logic [3:0] A_RX   = 4'h3;
    typedef enum {ST_IDLE, ST_RST, ST_ENBL, ST_GAP, ST_LEAD, ST_LO,
                  ST_HI, ST_END} hst_t;
    typedef struct packed {
        hst_t        st;
        logic [31:0] cnt;
        logic [15:0] tx;
        logic [15:0] sh;
        logic [15:0] rx;
        logic [4:0]  bitn;
        logic        go;
        logic        rst_req;
        logic        tog;
        logic [2:0]  ctl;
        logic        cs_n;
        logic        sck;
        logic        sdi;
        logic        wrst_n;
        logic        done;
        logic [15:0] rdata;
    } host_st_t;
    host_st_t s_r;
    host_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = '0;
        if (wr && addr == A_TX) begin
            s_nxt.tx = wdata;
            s_nxt.go = 1'b1;
        end
        if (wr && addr == A_CTRL) begin
            s_nxt.ctl = wdata[2:0];
            s_nxt.rst_req = s_nxt.rst_req | wdata[3];
        end
        if (rd) begin
            case (addr)
                A_TX:    s_nxt.rdata = s_r.tx;
                A_CTRL:  s_nxt.rdata = {13'h0, s_r.ctl};
                A_STAT:  s_nxt.rdata = {14'h0, s_r.done,
                                        s_r.st != ST_IDLE};
                A_RX:    s_nxt.rdata = s_r.rx;
                default: s_nxt.rdata = '0;
            endcase
        end
        if (s_r.cnt != 0)
            s_nxt.cnt = s_r.cnt - 32'h1;
        case (s_r.st)
            ST_IDLE: if (s_r.rst_req) begin
                // a reset request written in this very cycle stays pending
                s_nxt.rst_req = wr && (addr == A_CTRL) && wdata[3];
                s_nxt.wrst_n = 1'b0;
                s_nxt.cnt = WRST_CYC - 1;
                s_nxt.st = ST_RST;
            end else if (s_r.go && s_r.cnt == 0) begin
                // a word written now is kept for the next frame
                s_nxt.go = wr && (addr == A_TX);
                s_nxt.done = 1'b0;
                s_nxt.tog = !s_r.tog;
                s_nxt.sh = {!s_r.tog, s_r.tx[14:0]};
                s_nxt.cs_n = 1'b0;
                s_nxt.cnt = `CYC_LEAD - 1;
                s_nxt.st = ST_LEAD;
            end
            ST_RST: if (s_r.cnt == 0) begin
                s_nxt.wrst_n = 1'b1;
                s_nxt.cnt = ENBL_CYC;
                s_nxt.st = ST_ENBL;
            end
            ST_ENBL: if (s_r.cnt == 0) s_nxt.st = ST_IDLE;
            ST_LEAD: if (s_r.cnt == 0) begin
                s_nxt.sdi = s_r.sh[15];
                s_nxt.bitn = 5'h0;
                s_nxt.sck = 1'b1;
                s_nxt.cnt = `CYC_SCK_HALF - 1;
                s_nxt.st = ST_HI;
            end
            ST_HI: if (s_r.cnt == 0) begin
                s_nxt.sck = 1'b0;
                s_nxt.rx = {s_r.rx[14:0], link.sdo};
                s_nxt.sh = {s_r.sh[14:0], 1'b0};
                s_nxt.bitn = s_r.bitn + 5'h1;
                s_nxt.cnt = `CYC_SCK_HALF - 1;
                s_nxt.st = (s_r.bitn == 5'(`FRAME_BITS - 1))
                    ? ST_END : ST_LO;
            end
            ST_LO: if (s_r.cnt == 0) begin
                s_nxt.sdi = s_r.sh[15];
                s_nxt.sck = 1'b1;
                s_nxt.cnt = `CYC_SCK_HALF - 1;
                s_nxt.st = ST_HI;
            end
            ST_END: if (s_r.cnt == 0) begin
                s_nxt.cs_n = 1'b1;
                s_nxt.done = 1'b1;
                s_nxt.cnt = `CYC_CSB;
                s_nxt.st = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.cs_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.chip_select_n    = s_r.cs_n;
    assign link.sclk             = s_r.sck;
    assign link.sdi              = s_r.sdi;
    assign link.wake_reset_n     = s_r.wrst_n;
    assign link.direct_input_ch0 = s_r.ctl[0];
    assign link.direct_input_ch1 = s_r.ctl[1];
    assign link.pwm_clk          = s_r.ctl[2];
    assign rdata                 = s_r.rdata;
endmodule

// ### verif/switch_link_props.sv
// concurrent checks on the link between controller and switch
`timescale 1ns/1ps
module switch_link_props (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        chip_select_n,
    input wire logic        sclk,
    input wire logic        wake_reset_n,
    input wire logic        direct_input_ch0,
    input wire logic        sync_oe,
    input wire logic        switch_output_ch0,
    input wire logic        switch_output_ch1,
    input wire logic        sense_oe,
    input wire logic        fail_safe,
    input wire logic        vdd_ok,
    input wire logic [15:0] global_config_reg,
    input wire logic [1:0]  oc_window
);
    logic        sclk_q;
    logic [4:0]  rises;
    logic [11:0] run_cnt;
    logic [11:0] lead_cnt;
    logic [11:0] hi_cnt;
    logic [11:0] en_cnt;
    logic [11:0] lo_cnt;

    function automatic logic [11:0] inc(input logic [11:0] v);
        return (v == 12'hfff) ? v : v + 12'h001;
    endfunction

    // saturating run-length counters and a wrapping per-frame rise count; wider counts would only cost area
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q   <= 1'b0;
            rises    <= 5'h00;
            run_cnt  <= 12'h000;
            lead_cnt <= 12'h000;
            hi_cnt   <= 12'h000;
            en_cnt   <= 12'h000;
            lo_cnt   <= 12'h000;
        end else begin
            sclk_q   <= sclk;
            rises    <= chip_select_n ? 5'h00 : rises + 5'(sclk && !sclk_q);
            run_cnt  <= (sclk != sclk_q) ? 12'h001 : inc(run_cnt);
            lead_cnt <= chip_select_n ? 12'h000 : inc(lead_cnt);
            hi_cnt   <= chip_select_n ? inc(hi_cnt) : 12'h000;
            en_cnt   <= wake_reset_n ? inc(en_cnt) : 12'h000;
            lo_cnt   <= wake_reset_n ? 12'h000 : inc(lo_cnt);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    frame_bits_a: assert property ($rose(chip_select_n)
        |-> rises == 5'h10)
        else $error("frame closed without sixteen serial clocks");
    cs_sclk_low_a: assert property ($changed(chip_select_n) |-> !sclk)
        else $error("select moved while serial clock high");
    sclk_half_a: assert property (!chip_select_n && sclk != sclk_q
        |-> run_cnt >= 12'd13) else $error("serial clock phase too short");
    lead_time_a: assert property ($rose(sclk) && rises == 5'h00
        |-> lead_cnt >= 12'd100) else $error("first clock too soon");
    cs_gap_a: assert property ($fell(chip_select_n)
        |-> hi_cnt >= 12'd200) else $error("select gap too short");
    enbl_wait_a: assert property ($fell(chip_select_n)
        |-> en_cnt >= 12'd1000)
        else $error("select too soon after reset release");
    reset_width_a: assert property ($rose(wake_reset_n)
        |-> lo_cnt >= 12'd2000) else $error("reset pulse too short");
    sync_release_a: assert property ($fell(switch_output_ch0)
        || $fell(switch_output_ch1) |-> ##[0:2] !sync_oe)
        else $error("sync not released at turn-off");
    sense_tristate_a: assert property (
        (global_config_reg[5:4] == 2'h0) [*2] |-> !sense_oe)
        else $error("sense driven with select zero");
    oc_blank_a: assert property ((oc_window != 2'h0) [*2] |-> !sense_oe)
        else $error("sense driven in overcurrent window");
    no_sense_a: assert property ((fail_safe || !vdd_ok) [*2]
        |-> !sense_oe) else $error("sense driven without sensing");
    direct_follow_a: assert property ($changed(direct_input_ch0)
        && global_config_reg[1:0] == 2'h2 && !fail_safe
        |-> ##[1:3] (switch_output_ch0 == direct_input_ch0))
        else $error("channel does not follow direct input");
endmodule

// ### verif/tb.sv
// self-checking bench joining controller and switch ends
`timescale 1ns/1ps
module tb;
    localparam int unsigned IN_CYC   = 300;
    localparam int unsigned WDTO_CYC = 4000;
    localparam int          LIMIT    = 60000;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic [15:0] rdata;
    logic        vdd_ok = 1'b1;
    logic [1:0]  oc_over = 2'h0;
    logic        pwm_ext_tick = 1'b0;
    logic        switch_output_ch0;
    logic        switch_output_ch1;
    logic [1:0]  sense_output;
    logic        sense_oe;
    logic        hold_active;
    logic        asleep;
    logic        fail_safe;
    logic [15:0] global_config_reg;
    logic [1:0]  oc_window;
    logic [15:0] lfsr_r = 16'h005b;
    logic        tog_r;
    logic [31:0] exp_q[$];
    int          fails = 0;
    int          compares = 0;
    int          cyc = 0;

    switch_link_if link ();
    switch_ctrl_host i_switch_ctrl_host (.mclk(mclk), .rst_n(rst_n),
        .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    switch_ctrl_dev #(.IN_CYCLES(IN_CYC), .WDTO_CYCLES(WDTO_CYC))
    i_switch_ctrl_dev (.mclk(mclk), .rst_n(rst_n), .link(link),
        .vdd_ok(vdd_ok), .oc_over(oc_over), .pwm_ext_tick(pwm_ext_tick),
        .switch_output_ch0(switch_output_ch0),
        .switch_output_ch1(switch_output_ch1),
        .sense_output(sense_output), .sense_oe(sense_oe),
        .hold_active(hold_active), .asleep(asleep), .fail_safe(fail_safe),
        .global_config_reg(global_config_reg), .oc_window(oc_window));
    switch_link_props i_switch_link_props (.mclk(mclk), .rst_n(rst_n),
        .chip_select_n(link.chip_select_n), .sclk(link.sclk),
        .wake_reset_n(link.wake_reset_n),
        .direct_input_ch0(link.direct_input_ch0), .sync_oe(link.sync_oe),
        .switch_output_ch0(switch_output_ch0),
        .switch_output_ch1(switch_output_ch1), .sense_oe(sense_oe),
        .fail_safe(fail_safe), .vdd_ok(vdd_ok),
        .global_config_reg(global_config_reg), .oc_window(oc_window));

    always #2.5 mclk = ~mclk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // read data stand only in the cycle after the strobe
    always @(posedge mclk) begin : mon
        logic [31:0] e;
        if (rd_d) begin
            e = exp_q.pop_front();
            check(rdata & e[31:16], e[15:0]);
        end
        rd_d <= rd;
        cyc++;
        pwm_ext_tick <= cyc[5];
        if (cyc == LIMIT) begin
            fails++;
            final_report();
        end
    end

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [15:0] m,
                          input logic [15:0] d);
        exp_q.push_back({m, d});
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
    endtask

    task automatic wait_cs(input logic v);
        for (int i = 0; i < 3000 && link.chip_select_n !== v; i++)
            @(posedge mclk);
        check(16'(link.chip_select_n), 16'(v));
    endtask

    // frame out, then let the commit land before looking
    task automatic send(input logic [15:0] w);
        bus_wr(4'h0, w);
        wait_cs(1'b0);
        wait_cs(1'b1);
        repeat (4) @(posedge mclk);
        check(global_config_reg & 16'h7fff, w & 16'h7fff);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        check(16'(asleep), 16'h0001);
        check(16'(sense_oe), 16'h0000);
        bus_rd(4'h2, 16'hffff, 16'h0000);
        bus_rd(4'h3, 16'hffff, 16'h0000);
        bus_rd(4'hf, 16'hffff, 16'h0000);
        bus_wr(4'h1, 16'h0001);
        repeat (4) @(posedge mclk);
        check(16'(asleep), 16'h0000);
        bus_wr(4'h1, 16'h0000);
        repeat (IN_CYC - 20) @(posedge mclk);
        check(16'(asleep), 16'h0000);
        repeat (40) @(posedge mclk);
        check(16'(asleep), 16'h0001);
        bus_wr(4'h1, 16'h0008);
        for (int i = 0; i < 3000 && link.wake_reset_n !== 1'b1; i++)
            @(posedge mclk);
        check(16'(link.wake_reset_n), 16'h0001);
        bus_wr(4'h1, 16'h0003);
        send(16'h000a);
        tog_r = global_config_reg[15];
        for (int k = 0; k < 4; k++) begin
            send(16'h000a | 16'(k << 4));
            check(16'(sense_output), 16'(k));
            check(16'(sense_oe), 16'(k != 0));
            check(16'(global_config_reg[15]), 16'(!tog_r));
            check(16'(link.sync_oe), 16'(k != 0));
            tog_r = global_config_reg[15];
            // serial out carries the frame before the last one
            bus_rd(4'h3, 16'h7fff, (k == 0) ? 16'h000a
                   : 16'(16'h000a | (k - 1) << 4));
        end
        for (int i = 0; i < 6; i++) begin
            lfsr_r = lfsr(lfsr_r);
            bus_wr(4'h1, {14'h0000, lfsr_r[1:0]});
            repeat (4) @(posedge mclk);
            check(16'(switch_output_ch0), 16'(lfsr_r[0]));
            check(16'(switch_output_ch1), 16'(lfsr_r[1]));
        end
        // ch0 on the external pwm clock, ch1 still direct
        bus_wr(4'h1, 16'h0004);
        send(16'h0009);
        check(16'(switch_output_ch0), 16'h0001);
        check(16'(switch_output_ch1), 16'h0000);
        bus_wr(4'h1, 16'h0003);
        send(16'h005a);
        // both channels off so the overcurrent staircase restarts
        bus_wr(4'h1, 16'h0000);
        repeat (4) @(posedge mclk);
        check(16'(hold_active), 16'h0001);
        check(16'(sense_output), 16'h0001);
        bus_wr(4'h1, 16'h0003);
        oc_over <= 2'h1;
        repeat (50) @(posedge mclk);
        check(16'(oc_window), 16'h0001);
        check(16'(sense_oe), 16'h0000);
        repeat (200) @(posedge mclk);
        check(16'(oc_window), 16'h0000);
        check(16'(sense_oe), 16'h0001);
        oc_over <= 2'h0;
        vdd_ok  <= 1'b0;
        repeat (4) @(posedge mclk);
        check(16'(sense_oe), 16'h0000);
        vdd_ok  <= 1'b1;
        repeat (WDTO_CYC + 50) @(posedge mclk);
        check(16'(fail_safe), 16'h0001);
        check(16'(sense_oe), 16'h0000);
        final_report();
    end
endmodule
